// ==== pkg/prs_pkg.sv ====
// prs_pkg: constants, states and carrier types of the power, reset and park sequencer.
// assumes a single 200 MHz core clock with a synchronous, active-high reset.
package prs_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;    // core clock period
   localparam int FILT_NS       = 150;  // slow edge the park filter must ride out
   // least time: round up; the filter switches one cycle after the count reaches it, so a 150 ns wobble never passes
   localparam int FILT_CYC      = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PARK_US       = 500;  // longest park duration
   // longest time: round down
   localparam int PARK_CYC      = (PARK_US * 1000) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // configuration flash read
   // ----------------------------------------------------------------
   localparam int        SPI_DIV    = 6;        // 200 MHz / 6 = 33.3 MHz serial clock
   localparam logic [2:0] SPI_LAST  = 3'h5;     // last divider phase
   localparam logic [2:0] SPI_HIGH  = 3'h3;     // first phase with clock high
   localparam logic [7:0] FAST_RD   = 8'h0b;    // fast read opcode
   localparam logic [23:0] CFG_ADDR = 24'h000000; // start of configuration image
   localparam logic [7:0] DUMMY     = 8'h00;    // dummy byte content
   localparam int        HDR_BITS   = 40;       // opcode, address, dummy
   localparam int        CFG_BYTES  = 4;        // configuration bytes read
   localparam logic [6:0] HDR_LAST  = 7'(HDR_BITS - 1);
   localparam logic [6:0] BIT_LAST  = 7'(HDR_BITS + 8 * CFG_BYTES - 1);

   // ----------------------------------------------------------------
   // states and carriers
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_PLL_WAIT, ST_SHIFT, ST_READY, ST_PARK, ST_PARKED} prs_state_e;

   // one configuration byte handed to the rest of the controller
   typedef struct packed {
      logic [7:0] index;
      logic [7:0] data;
   } prs_cfg_s;

   // outputs that float during reset
   typedef struct packed {
      logic mirror_power_enable;
      logic led_driver_on;
      logic led_select_lo;
      logic led_select_hi;
      logic flash_serial_clock;
      logic flash_serial_out;
      logic flash_chip_select_n;
   } prs_pins_s;

endpackage : prs_pkg

// ==== core/prs_park_seq.sv ====
// prs_park_seq: power-up initialisation, reset release, busy status and park sequence.
// assumes the external reset and park level come from a power monitor; pll lock from
// the on-chip pll; the flash data pin is asynchronous to the core clock.
`timescale 1ns/100ps
module prs_park_seq #(
   parameter int PARK_CYCLES = prs_pkg::PARK_CYC  // park duration, shorten in simulation
) (
   input  wire logic              i_mclk,                 // core clock, 200 MHz
   input  wire logic              i_rst,                  // synchronous reset, active high
   input  wire logic              i_park,                 // power good, low asks to park
   input  wire logic              i_pll_locked,           // pll lock from this clock domain
   input  wire logic              i_flash_serial_in,      // flash data pin, asynchronous
   output logic                   o_init_status_pin,      // high while auto-init busy
   output prs_pkg::prs_pins_s     o_pins,                 // floating output group
   output logic                   o_pins_oe,              // enable for the whole group
   output logic                   o_cfg_valid,            // one-cycle byte strobe
   output prs_pkg::prs_cfg_s      o_cfg,                  // configuration byte
   output logic                   o_park_done             // park finished, level
);

   // ----------------------------------------------------------------
   // park input synchroniser and filter
   // ----------------------------------------------------------------
   logic                park_s1_reg;        // first stage, read only by second
   logic                park_s2_reg;        // synchronised park
   logic                park_filt_reg;      // filtered park
   logic                park_filt_next;
   logic [5:0]          filt_cnt_reg;       // cycles park has disagreed
   logic [5:0]          filt_cnt_next;
   logic                din_s1_reg;         // flash data, first stage
   logic                din_s2_reg;         // flash data, synchronised

   // filter next state
   always_comb
   begin
      park_filt_next = park_filt_reg;
      filt_cnt_next  = 6'h00;
      if (park_s2_reg != park_filt_reg)
      begin
         if (filt_cnt_reg == 6'(prs_pkg::FILT_CYC))
            // disagreed longer than the slow-edge window
            park_filt_next = park_s2_reg;
         else
            filt_cnt_next = filt_cnt_reg + 6'h01;
      end
   end

   // synchronisers and filter registers
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         park_s1_reg   <= 1'b0;
         park_s2_reg   <= 1'b0;
         park_filt_reg <= 1'b0;
         filt_cnt_reg  <= 6'h00;
         din_s1_reg    <= 1'b0;
         din_s2_reg    <= 1'b0;
      end
      else
      begin
         // two stages before the filter looks
         park_s1_reg   <= i_park;
         park_s2_reg   <= park_s1_reg;
         park_filt_reg <= park_filt_next;
         filt_cnt_reg  <= filt_cnt_next;
         din_s1_reg    <= i_flash_serial_in;
         din_s2_reg    <= din_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // sequencer and flash reader
   // ----------------------------------------------------------------
   prs_pkg::prs_state_e state_reg, state_next;
   logic [2:0]          div_reg, div_next;          // serial clock phase
   logic [6:0]          bit_reg, bit_next;          // bit being transferred
   logic [39:0]         sh_reg, sh_next;            // outgoing header
   logic [7:0]          rx_reg, rx_next;            // incoming byte
   logic [16:0]         park_cnt_reg, park_cnt_next; // park elapsed cycles
   logic                armed_reg, armed_next;      // park seen high once
   logic                busy_reg, busy_next;
   logic                oe_reg, oe_next;
   logic                done_reg, done_next;
   logic                cfg_valid_reg, cfg_valid_next;
   prs_pkg::prs_cfg_s   cfg_reg, cfg_next;
   prs_pkg::prs_pins_s  pins_reg, pins_next;

   // next-state logic for the whole sequence
   always_comb
   begin
      state_next     = state_reg;
      div_next       = div_reg;
      bit_next       = bit_reg;
      sh_next        = sh_reg;
      rx_next        = rx_reg;
      park_cnt_next  = park_cnt_reg;
      armed_next     = armed_reg | park_filt_reg;
      cfg_valid_next = 1'b0;
      cfg_next       = cfg_reg;
      pins_next      = pins_reg;
      case (state_reg)
         // wait for lock before touching the flash
         prs_pkg::ST_PLL_WAIT:
         begin
            if (i_pll_locked)
            begin
               // first bit goes out with chip select, clock still low
               pins_next.flash_chip_select_n = 1'b0;
               pins_next.flash_serial_out    = sh_reg[39];
               sh_next                       = {sh_reg[38:0], 1'b0};
               div_next                      = 3'h1;
               state_next                    = prs_pkg::ST_SHIFT;
            end
         end
         // mode 0: change on falling edge, sample near rising
         prs_pkg::ST_SHIFT:
         begin
            div_next = (div_reg == prs_pkg::SPI_LAST) ? 3'h0 : div_reg + 3'h1;
            pins_next.flash_serial_clock = (div_next >= prs_pkg::SPI_HIGH);
            if (div_reg == prs_pkg::SPI_LAST)
            begin
               // data is two cycles late through the synchroniser, so sample at phase end
               rx_next = {rx_reg[6:0], din_s2_reg};
               if (bit_reg > prs_pkg::HDR_LAST && bit_reg[2:0] == 3'h7)
               begin
                  cfg_valid_next = 1'b1;
                  cfg_next.data  = {rx_reg[6:0], din_s2_reg};
                  cfg_next.index = {4'h0, 4'((bit_reg - 7'(prs_pkg::HDR_BITS)) >> 3)};
               end
               if (bit_reg == prs_pkg::BIT_LAST)
               begin
                  pins_next.flash_chip_select_n = 1'b1;
                  pins_next.flash_serial_clock  = 1'b0;
                  state_next                    = prs_pkg::ST_READY;
               end
               else
               begin
                  pins_next.flash_serial_out = sh_reg[39];
                  sh_next                    = {sh_reg[38:0], 1'b0};
                  bit_next                   = bit_reg + 7'h01;
               end
            end
         end
         // normal operation, leds may run
         prs_pkg::ST_READY:
         begin
            pins_next.led_driver_on = 1'b1;
         end
         prs_pkg::ST_PARK:
         begin
            pins_next.led_driver_on = 1'b0;
            park_cnt_next           = park_cnt_reg + 17'h00001;
            if (park_cnt_reg == 17'(PARK_CYCLES - 1))
            begin
               // mirror power enable falls at end of park
               pins_next.mirror_power_enable = 1'b0;
               state_next                    = prs_pkg::ST_PARKED;
            end
         end
         default:
         begin
            pins_next.led_driver_on = 1'b0;
         end
      endcase
      // park request overrides init and normal operation
      if (armed_reg && !park_filt_reg && state_reg != prs_pkg::ST_PARK
          && state_reg != prs_pkg::ST_PARKED)
      begin
         pins_next.flash_chip_select_n = 1'b1;
         pins_next.flash_serial_clock  = 1'b0;
         pins_next.led_driver_on       = 1'b0;
         park_cnt_next                 = 17'h00000;
         state_next                    = prs_pkg::ST_PARK;
      end
      // busy while the init routine runs
      busy_next = (state_next == prs_pkg::ST_PLL_WAIT) || (state_next == prs_pkg::ST_SHIFT);
      oe_next   = 1'b1;
      done_next = (state_next == prs_pkg::ST_PARKED);
   end

   // sequencer registers
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         state_reg     <= prs_pkg::ST_PLL_WAIT;
         div_reg       <= 3'h0;
         bit_reg       <= 7'h00;
         sh_reg        <= {prs_pkg::FAST_RD, prs_pkg::CFG_ADDR, prs_pkg::DUMMY};
         rx_reg        <= 8'h00;
         park_cnt_reg  <= 17'h00000;
         armed_reg     <= 1'b0;
         busy_reg      <= 1'b0;
         done_reg      <= 1'b0;
         cfg_valid_reg <= 1'b0;
         cfg_reg       <= '0;
         // floated group disabled, idle values behind it
         oe_reg        <= 1'b0;
         pins_reg      <= '{mirror_power_enable: 1'b1, flash_chip_select_n: 1'b1,
                            default: 1'b0};
      end
      else
      begin
         state_reg     <= state_next;
         div_reg       <= div_next;
         bit_reg       <= bit_next;
         sh_reg        <= sh_next;
         rx_reg        <= rx_next;
         park_cnt_reg  <= park_cnt_next;
         armed_reg     <= armed_next;
         busy_reg      <= busy_next;
         done_reg      <= done_next;
         cfg_valid_reg <= cfg_valid_next;
         cfg_reg       <= cfg_next;
         oe_reg        <= oe_next;
         pins_reg      <= pins_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------------------------------
   assign o_init_status_pin = busy_reg;
   assign o_pins            = pins_reg;
   assign o_pins_oe         = oe_reg;
   assign o_cfg_valid       = cfg_valid_reg;
   assign o_cfg             = cfg_reg;
   assign o_park_done       = done_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   busy_rise_a: assert property (@(posedge i_mclk) $fell(i_rst) |=> o_init_status_pin)
      else $error("busy not high after reset release");
   busy_fall_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      $fell(o_init_status_pin) |-> state_reg != prs_pkg::ST_SHIFT && $past(bit_reg) ==
      prs_pkg::BIT_LAST || state_reg == prs_pkg::ST_PARK)
      else $error("busy fell before load finished");
   float_rst_a: assert property (@(posedge i_mclk) $past(i_rst) |-> !o_pins_oe)
      else $error("group driven during reset");
   stat_rst_a: assert property (@(posedge i_mclk) $past(i_rst) |->
      !o_init_status_pin && !o_cfg_valid && !o_park_done)
      else $error("status active during reset");
   filt_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      $changed(park_filt_reg) |-> $past(filt_cnt_reg) == 6'(prs_pkg::FILT_CYC))
      else $error("park changed before filter window");
   sync_path_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      $changed(park_filt_reg) |-> park_filt_reg == $past(park_s2_reg))
      else $error("filter followed unsynchronised park");
   pll_first_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      $fell(o_pins.flash_chip_select_n) |-> $past(i_pll_locked))
      else $error("flash read before pll lock");
   opcode_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      $fell(o_pins.flash_chip_select_n) |-> o_pins.flash_serial_out == prs_pkg::FAST_RD[7]
      && sh_reg[39:33] == prs_pkg::FAST_RD[6:0])
      else $error("read does not start with fast read opcode");
   spi_mode0_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_pins.flash_chip_select_n |-> !o_pins.flash_serial_clock)
      else $error("serial clock not idle low");
   park_len_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      state_reg == prs_pkg::ST_PARK |-> park_cnt_reg < 17'(PARK_CYCLES))
      else $error("park exceeded its time");
   pwr_drop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      $rose(o_park_done) |-> !o_pins.mirror_power_enable && $past(o_pins.mirror_power_enable))
      else $error("mirror power enable not dropped with park end");

endmodule // prs_park_seq

// ==== testbench/prs_flash_model.sv ====
// prs_flash_model: behavioural serial flash serving one mode 0 read.
// assumes the bench resolves floating pins before they reach it.
`timescale 1ns/100ps
module prs_flash_model #(
   parameter logic [31:0] IMAGE = 32'hc35a96e1  // words served after the header
) (
   input  wire logic        i_sclk,  // serial clock, still outside frames
   input  wire logic        i_cs_n,  // chip select, active low
   input  wire logic        i_mosi,  // command and address bits
   output logic             o_miso,  // data back to the device
   output logic [39:0]      o_hdr    // header bits seen, for the bench
);
   // ------------------------------------------------------------
   // frame state
   // ------------------------------------------------------------
   int   bit_cnt = 0;  // rising edges in this frame
   logic drv     = 0;  // last bit put out

   always @(posedge i_sclk or posedge i_cs_n)
   begin
      if (i_cs_n)
         bit_cnt <= 0;
      else
      begin
         if (bit_cnt < 40)
            o_hdr <= {o_hdr[38:0], i_mosi};
         bit_cnt <= bit_cnt + 1;
      end
   end

   always @(negedge i_sclk)
   begin
      if (!i_cs_n && bit_cnt >= 40 && bit_cnt < 72)
         drv <= IMAGE[71 - bit_cnt];
   end

   // deselected: show the inverse so a stale value never passes
   assign o_miso = i_cs_n ? ~drv : drv;
endmodule // prs_flash_model

// ==== testbench/tb.sv ====
// tb: self-checking bench for the power, reset and park sequencer.
// assumes the bench plays power monitor and the flash model answers.
`timescale 1ns/100ps
module tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int          PARK_N = 50;            // shortened park time
   localparam logic [31:0] IMG    = 32'hc35a96e1;  // flash content
   logic               i_mclk, i_rst, i_park, i_pll_locked;
   logic               miso, busy, oe, cfg_valid, park_done;
   prs_pkg::prs_pins_s pins;                       // floating group
   prs_pkg::prs_cfg_s  cfg;                        // config byte
   logic [39:0]        hdr;                        // header seen by flash
   logic [7:0]         got [4];                    // bytes received
   int                 fail_count, total_checks, nbytes, cyc, n;
   realtime            t0, t1;                     // last two serial edges
   // float resolution: clock parks low, chip select pulled up
   wire sclk_w = oe & pins.flash_serial_clock;
   wire cs_w   = oe ? pins.flash_chip_select_n : 1'b1;
   wire mosi_w = oe ? pins.flash_serial_out : 1'b1;

   prs_park_seq #(.PARK_CYCLES(PARK_N)) DUT (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_park(i_park), .i_pll_locked(i_pll_locked), .i_flash_serial_in(miso),
      .o_init_status_pin(busy), .o_pins(pins), .o_pins_oe(oe),
      .o_cfg_valid(cfg_valid), .o_cfg(cfg), .o_park_done(park_done));
   prs_flash_model #(.IMAGE(IMG)) FLASH (.i_sclk(sclk_w), .i_cs_n(cs_w),
      .i_mosi(mosi_w), .o_miso(miso), .o_hdr(hdr));

   // ------------------------------------------------------------
   // clock, monitors, timeout
   // ------------------------------------------------------------
   initial
   begin
      i_mclk = 0;
      forever #2.5 i_mclk = ~i_mclk;
   end
   always @(posedge sclk_w)
   begin
      t0 = t1;
      t1 = $realtime;
   end
   // byte collector; the ceiling covers all scenarios about four times over
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cfg_valid === 1'b1)
      begin
         got[cfg.index[1:0]] = cfg.data;
         nbytes++;
      end
      if (cyc == 4000)
      begin
         fail_count++;
         give_verdict();
      end
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [39:0] g, input logic [39:0] e, input string m);
      total_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic cycles(input int k);
      repeat (k) @(negedge i_mclk);
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // power-up: reset held, park raised before release
   task automatic t_reset();
      i_park = 1;
      cycles(12);
      chk({busy, oe, cfg_valid, park_done}, 0, "outputs active in reset");
   endtask
   // release, lock wait, flash load, busy fall
   task automatic t_init();
      nbytes = 0;
      i_rst  = 0;
      cycles(1);
      chk({busy, oe}, 2'b11, "busy or pins not up");
      cycles(20);
      chk({busy, pins.flash_chip_select_n}, 2'b11, "read before lock");
      i_pll_locked = 1;
      for (n = 0; n < 600 && busy === 1'b1; n++)  // host waits for busy low
         cycles(1);
      cycles(1);
      chk(40'(n >= 430 && n <= 440), 1, "busy fall time");
      chk(hdr, {8'h0b, 32'h0}, "read header");
      chk(40'(int'(t1 - t0)), 30, "serial clock period");
      chk(40'(nbytes), 4, "byte count");
      chk({got[0], got[1], got[2], got[3]}, IMG, "config bytes");
      chk({pins.led_driver_on, pins.mirror_power_enable}, 2'b11, "ready pins");
      chk({pins.led_select_lo, pins.led_select_hi}, 0, "led selects driven");
   endtask
   // dips up to 150 ns never park
   task automatic t_filter();
      foreach (got[i])
      begin
         i_park = 0;
         cycles(i == 0 ? 30 : 4 * i);
         i_park = 1;
         cycles(40);
         chk({pins.led_driver_on, park_done}, 2'b10, "short dip parked");
      end
   endtask
   // real park request, then park high again ignored
   task automatic t_park();
      i_park = 0;
      for (n = 0; n < 200 && park_done !== 1'b1; n++)
         cycles(1);
      chk(40'(n >= PARK_N && n <= PARK_N + 40), 1, "park duration");
      chk({pins.mirror_power_enable, pins.led_driver_on}, 0, "mirror power on");
      i_park = 1;
      cycles(60);  // supplies kept past the power drop
      chk(park_done, 1, "park undone");
   endtask
   // second reset, park lands in mid read and aborts it
   task automatic t_abort();
      i_rst = 1;
      cycles(4);
      chk(oe, 0, "pins driven in reset");
      i_rst  = 0;
      nbytes = 0;
      cycles(100);
      i_park = 0;
      for (n = 0; n < 200 && park_done !== 1'b1; n++)
         cycles(1);
      chk({park_done, pins.flash_chip_select_n, pins.flash_serial_clock}, 3'b110,
          "read not aborted");
      chk(40'(nbytes), 0, "bytes after abort");
   endtask

   // main sequence, inputs driven at falling edges
   initial
   begin
      i_rst        = 1;
      i_park       = 0;
      i_pll_locked = 0;
      fail_count   = 0;
      total_checks = 0;
      nbytes       = 0;
      cyc          = 0;
      t_reset();
      t_init();
      t_filter();
      t_park();
      t_abort();
      give_verdict();
   end
endmodule // tb
